// ---- rtl/esed_pkg.sv ----
package esed_pkg;
  // Register byte offsets
  localparam logic [7:0] ESED_CMD_OFF    = 8'h20;
  localparam logic [7:0] ESED_STS_OFF    = 8'h24;
  localparam logic [7:0] ESED_INTEN_OFF  = 8'h28;
  localparam logic [7:0] ESED_PLBASE_OFF = 8'h34;
  localparam logic [7:0] ESED_ALADDR_OFF = 8'h38;
  localparam logic [7:0] ESED_THR_OFF    = 8'h40;
  // Field positions
  localparam int ESED_DOORBELL_BIT = 6;
  localparam int ESED_ASYNC_EN_BIT = 5;
  localparam int ESED_PER_EN_BIT   = 4;
  localparam int ESED_ADV_STS_BIT  = 5;
  // Reset values and address masks
  localparam logic [31:0] ESED_ZERO       = 32'h0000_0000;
  localparam logic [7:0]  ESED_THR_RESET  = 8'h08;
  localparam logic [31:0] ESED_ALIGN_MASK = 32'hFFFF_FFE0;
  localparam logic [31:0] ESED_PL_MASK    = 32'hFFFF_F000;
  // AXI responses
  localparam logic [1:0] ESED_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ESED_RESP_SLVERR = 2'h2;
  // Doorbell flow states
  typedef enum logic [1:0] {
    ESED_IDLE  = 2'h0,
    ESED_EVICT = 2'h1,
    ESED_DONE  = 2'h3
  } esed_state_e;
endpackage : esed_pkg

// ---- rtl/esed_evict_if.sv ----
`timescale 1ns/10ps
interface esed_evict_if;
  logic ring;
  logic evicted;
  logic flag_set;
  modport ctrl (output ring, input evicted, output flag_set);
  modport seq  (input ring, output evicted, input flag_set);
endinterface : esed_evict_if

// ---- rtl/esed_doorbell_seq.sv ----
`timescale 1ns/10ps
module esed_doorbell_seq
  import esed_pkg::*;
#(
  parameter int EVICT_CYCLES = 4
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  resetn,
  // Control link
  esed_evict_if.seq  lnk
);
  logic [7:0] cnt_r;
  // Model of cache eviction latency after the doorbell
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
    end else if (lnk.flag_set) begin
      cnt_r <= 8'h00;
    end else if (lnk.ring && !lnk.evicted) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign lnk.evicted = lnk.ring && (cnt_r >= 8'(EVICT_CYCLES));
endmodule : esed_doorbell_seq

// ---- rtl/esed_top.sv ----
`timescale 1ns/10ps
module esed_top
  import esed_pkg::*;
#(
  parameter int EVICT_CYCLES = 4
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Schedule engine side
  input  wire logic        frame_tick,
  output logic             async_fetch_en,
  output logic [31:0]      async_fetch_addr,
  output logic             periodic_fetch_en,
  output logic [31:0]      periodic_fetch_addr,
  // Interrupt
  output logic             irq
);
  logic        async_schedule_enable_r;
  logic        periodic_schedule_enable_r;
  logic        async_advance_doorbell_r;
  logic        async_advance_status_r;
  logic        async_advance_int_enable_r;
  logic        irq_r;
  logic [31:0] async_list_address_r;
  logic [31:0] periodic_frame_list_base_r;
  logic [7:0]  thr_r;
  logic [7:0]  thr_cnt_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;
  logic        wr_ok;
  logic        thr_edge;
  logic [31:0] rd_word;
  logic        rd_ok;
  esed_state_e state_r;
  esed_evict_if lnk ();

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == ESED_CMD_OFF) || (a == ESED_STS_OFF) || (a == ESED_INTEN_OFF) ||
           (a == ESED_PLBASE_OFF) || (a == ESED_ALADDR_OFF) || (a == ESED_THR_OFF);
  endfunction : mapped

  // Write channel: address and data captured in either order
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r;
  assign wr_ok   = mapped(awaddr_r);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= ESED_ZERO;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ESED_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ESED_RESP_OKAY : ESED_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] wcmd;
  assign wcmd = merge(ESED_ZERO, wdata_r, wstrb_r);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      async_schedule_enable_r    <= 1'b0;
      periodic_schedule_enable_r <= 1'b0;
    end else if (wr_fire && awaddr_r == ESED_CMD_OFF && wstrb_r[0]) begin
      async_schedule_enable_r    <= wcmd[ESED_ASYNC_EN_BIT];
      periodic_schedule_enable_r <= wcmd[ESED_PER_EN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      async_advance_doorbell_r <= 1'b0;
    end else if (state_r == ESED_DONE) begin
      async_advance_doorbell_r <= 1'b0;
    end else if (wr_fire && awaddr_r == ESED_CMD_OFF && wstrb_r[0] &&
                 wcmd[ESED_DOORBELL_BIT]) begin
      async_advance_doorbell_r <= 1'b1;
    end
  end

  // Doorbell flow: ring, wait for eviction, set flag, clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= ESED_IDLE;
    end else begin
      case (state_r)
        ESED_IDLE: begin
          if (async_advance_doorbell_r) begin
            state_r <= ESED_EVICT;
          end
        end
        ESED_EVICT: begin
          if (lnk.evicted) begin
            state_r <= ESED_DONE;
          end
        end
        ESED_DONE: begin
          state_r <= ESED_IDLE;
        end
        default: begin
          state_r <= ESED_IDLE;
        end
      endcase
    end
  end

  assign lnk.ring     = (state_r == ESED_EVICT);
  assign lnk.flag_set = (state_r == ESED_EVICT) && lnk.evicted;

  esed_doorbell_seq #(
    .EVICT_CYCLES (EVICT_CYCLES)
  ) u_seq (
    .clock  (clock),
    .resetn (resetn),
    .lnk    (lnk)
  );

  always_ff @(posedge clock) begin
    if (!resetn) begin
      async_advance_status_r <= 1'b0;
    end else if (lnk.flag_set) begin
      async_advance_status_r <= 1'b1;
    end else if (wr_fire && awaddr_r == ESED_STS_OFF && wstrb_r[0] &&
                 wcmd[ESED_ADV_STS_BIT]) begin
      async_advance_status_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      async_advance_int_enable_r <= 1'b0;
      async_list_address_r       <= ESED_ZERO;
      periodic_frame_list_base_r <= ESED_ZERO;
      thr_r                      <= ESED_THR_RESET;
    end else if (wr_fire) begin
      if (awaddr_r == ESED_INTEN_OFF && wstrb_r[0]) begin
        async_advance_int_enable_r <= wcmd[ESED_ADV_STS_BIT];
      end
      if (awaddr_r == ESED_ALADDR_OFF) begin
        async_list_address_r <= merge(async_list_address_r, wdata_r, wstrb_r) & ESED_ALIGN_MASK;
      end
      if (awaddr_r == ESED_PLBASE_OFF) begin
        periodic_frame_list_base_r <= merge(periodic_frame_list_base_r, wdata_r, wstrb_r)
                                      & ESED_PL_MASK;
      end
      if (awaddr_r == ESED_THR_OFF && wstrb_r[0]) begin
        thr_r <= wdata_r[7:0];
      end
    end
  end

  // Threshold boundary counted in frame ticks
  assign thr_edge = frame_tick && (thr_cnt_r + 8'h01 >= thr_r);
  always_ff @(posedge clock) begin
    if (!resetn) begin
      thr_cnt_r <= 8'h00;
    end else if (thr_edge) begin
      thr_cnt_r <= 8'h00;
    end else if (frame_tick) begin
      thr_cnt_r <= thr_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else if (!(async_advance_status_r && async_advance_int_enable_r)) begin
      irq_r <= 1'b0;
    end else if (thr_edge) begin
      irq_r <= 1'b1;
    end
  end
  assign irq = irq_r;

  assign async_fetch_en      = async_schedule_enable_r;
  assign async_fetch_addr    = async_schedule_enable_r ? async_list_address_r : ESED_ZERO;
  assign periodic_fetch_en   = periodic_schedule_enable_r;
  assign periodic_fetch_addr = periodic_schedule_enable_r ? periodic_frame_list_base_r
                                                          : ESED_ZERO;

  // Read channel, one cycle answer
  always_comb begin
    rd_word = ESED_ZERO;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      ESED_CMD_OFF: begin
        rd_word[ESED_DOORBELL_BIT] = async_advance_doorbell_r;
        rd_word[ESED_ASYNC_EN_BIT] = async_schedule_enable_r;
        rd_word[ESED_PER_EN_BIT]   = periodic_schedule_enable_r;
      end
      ESED_STS_OFF:    rd_word[ESED_ADV_STS_BIT] = async_advance_status_r;
      ESED_INTEN_OFF:  rd_word[ESED_ADV_STS_BIT] = async_advance_int_enable_r;
      ESED_PLBASE_OFF: rd_word = periodic_frame_list_base_r;
      ESED_ALADDR_OFF: rd_word = async_list_address_r;
      ESED_THR_OFF:    rd_word[7:0] = thr_r;
      default:         rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= ESED_ZERO;
      s_axi_rresp  <= ESED_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? ESED_RESP_OKAY : ESED_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // doorbell cleared two cycles after flag set, one cycle after status is set
  a_doorbell_clear: assert property (@(posedge clock) disable iff (!resetn)
    lnk.flag_set |=> async_advance_status_r ##1 !async_advance_doorbell_r)
    else $error("doorbell not cleared after flag");

  a_flag_after_evict: assert property (@(posedge clock) disable iff (!resetn)
    $rose(async_advance_status_r) |-> $past(state_r == ESED_EVICT && lnk.evicted))
    else $error("status set without eviction");

  sequence s_ring;
    async_advance_doorbell_r && state_r == ESED_IDLE;
  endsequence
  a_ring_to_flag: assert property (@(posedge clock) disable iff (!resetn)
    s_ring |-> ##[1:300] async_advance_status_r)
    else $error("doorbell never answered");

  // interrupt only with enable and status
  a_irq_cause: assert property (@(posedge clock) disable iff (!resetn)
    irq |-> $past(async_advance_status_r && async_advance_int_enable_r))
    else $error("irq without enabled status");

  a_irq_boundary: assert property (@(posedge clock) disable iff (!resetn)
    $rose(irq) |-> $past(thr_edge))
    else $error("irq off threshold boundary");

  a_async_gate: assert property (@(posedge clock) disable iff (!resetn)
    async_fetch_en |-> async_fetch_addr == async_list_address_r)
    else $error("async fetch address wrong");

  a_async_skip: assert property (@(posedge clock) disable iff (!resetn)
    !async_schedule_enable_r |-> !async_fetch_en && async_fetch_addr == ESED_ZERO)
    else $error("async schedule not skipped");

  a_per_skip: assert property (@(posedge clock) disable iff (!resetn)
    !periodic_schedule_enable_r |-> !periodic_fetch_en && periodic_fetch_addr == ESED_ZERO)
    else $error("periodic schedule not skipped");

  a_per_base: assert property (@(posedge clock) disable iff (!resetn)
    periodic_fetch_en |-> periodic_fetch_addr == periodic_frame_list_base_r)
    else $error("periodic base wrong");
endmodule : esed_top

// ---- tb/ehci_schedule_enable_doorbell_bench.sv ----
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module ehci_schedule_enable_doorbell_bench;
  import esed_pkg::*;
  logic        clock;
  logic        resetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        frame_tick;
  logic        async_fetch_en;
  logic [31:0] async_fetch_addr;
  logic        periodic_fetch_en;
  logic [31:0] periodic_fetch_addr;
  logic        irq;
  int          bad_count;
  int          comparisons;
  logic [31:0] rd_data;
  logic [1:0]  rsp;

  esed_top #(.EVICT_CYCLES(4)) uut (
    .clock(clock), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_tick(frame_tick),
    .async_fetch_en(async_fetch_en), .async_fetch_addr(async_fetch_addr),
    .periodic_fetch_en(periodic_fetch_en), .periodic_fetch_addr(periodic_fetch_addr),
    .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    rsp     = s_axi_rresp;
  endtask : axi_rd

  task automatic tick();
    @(posedge clock);
    frame_tick <= 1'b1;
    @(posedge clock);
    frame_tick <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : tick

  task automatic ring_and_wait();
    int n;
    axi_wr(ESED_CMD_OFF, 32'h0000_0060);
    n = 0;
    do begin
      axi_rd(ESED_STS_OFF);
      n++;
    end while (rd_data[5] !== 1'b1 && n < 50);
  endtask : ring_and_wait

  task automatic test_reset_values();
    axi_rd(ESED_CMD_OFF);
    `CHK("cmd reset", 32'h0000_0000, rd_data)
    axi_rd(ESED_THR_OFF);
    `CHK("threshold reset", ESED_THR_RESET, rd_data[7:0])
    `CHK("async fetch idle", 1'b0, async_fetch_en)
    `CHK("periodic fetch idle", 1'b0, periodic_fetch_en)
    `CHK("irq idle", 1'b0, irq)
  endtask : test_reset_values

  task automatic test_enables();
    axi_wr(ESED_ALADDR_OFF, 32'h1234_5660);
    axi_wr(ESED_PLBASE_OFF, 32'hABCD_E000);
    `CHK("mapped wr resp", ESED_RESP_OKAY, rsp)
    axi_wr(ESED_CMD_OFF, 32'h0000_0010);
    repeat (2) @(posedge clock);
    `CHK("periodic fetch on", 1'b1, periodic_fetch_en)
    `CHK("periodic base", 32'hABCD_E000, periodic_fetch_addr)
    `CHK("async still off", 1'b0, async_fetch_en)
    `CHK("async addr off", 32'h0000_0000, async_fetch_addr)
    axi_wr(ESED_CMD_OFF, 32'h0000_0020);
    repeat (2) @(posedge clock);
    `CHK("async fetch on", 1'b1, async_fetch_en)
    `CHK("async list addr", 32'h1234_5660, async_fetch_addr)
    `CHK("periodic off", 1'b0, periodic_fetch_en)
    `CHK("periodic addr off", 32'h0000_0000, periodic_fetch_addr)
  endtask : test_enables

  task automatic test_doorbell_irq();
    axi_wr(ESED_THR_OFF, 32'h0000_0002);
    axi_wr(ESED_INTEN_OFF, 32'h0000_0020);
    ring_and_wait();
    `CHK("advance status set", 1'b1, rd_data[5])
    axi_rd(ESED_CMD_OFF);
    `CHK("doorbell cleared", 1'b0, rd_data[6])
    `CHK("enable kept", 1'b1, rd_data[5])
    `CHK("irq waits boundary", 1'b0, irq)
    tick();
    `CHK("irq mid threshold", 1'b0, irq)
    tick();
    `CHK("irq at boundary", 1'b1, irq)
    axi_wr(ESED_STS_OFF, 32'h0000_0020);
    repeat (2) @(posedge clock);
    `CHK("irq after clear", 1'b0, irq)
    axi_rd(ESED_STS_OFF);
    `CHK("status cleared", 1'b0, rd_data[5])
  endtask : test_doorbell_irq

  task automatic test_masked();
    axi_wr(ESED_INTEN_OFF, 32'h0000_0000);
    ring_and_wait();
    `CHK("status masked case", 1'b1, rd_data[5])
    repeat (2) tick();
    `CHK("irq masked", 1'b0, irq)
    axi_wr(ESED_INTEN_OFF, 32'h0000_0020);
    tick();
    `CHK("irq unmask mid count", 1'b0, irq)
    tick();
    `CHK("irq on unmask", 1'b1, irq)
    axi_wr(ESED_INTEN_OFF, 32'h0000_0000);
    repeat (2) @(posedge clock);
    `CHK("irq on mask", 1'b0, irq)
  endtask : test_masked

  task automatic test_unmapped();
    axi_rd(8'h00);
    `CHK("unmapped resp", ESED_RESP_SLVERR, rsp)
    `CHK("unmapped data", 32'h0000_0000, rd_data)
    axi_wr(8'h04, 32'hFFFF_FFFF);
    `CHK("unmapped wr resp", ESED_RESP_SLVERR, rsp)
  endtask : test_unmapped

  // Watchdog well above the roughly 140 cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    wrap_up();
  end

  initial begin
    bad_count     = 0;
    comparisons   = 0;
    resetn        = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    frame_tick    = 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    test_reset_values();
    test_enables();
    test_doorbell_irq();
    test_masked();
    test_unmapped();
    wrap_up();
  end
endmodule : ehci_schedule_enable_doorbell_bench
